// ### verilog/mfmc_top.v
// mode, partition, boot, sleep and reset control of a managed flash device
`timescale 1ns/10ps
`default_nettype none
`include "mfmc_regs.vh"
module mfmc_top #(
	parameter [31:0] IDLE_CYC = `MFMC_IDLE_CYC,
	parameter [31:0] BACK_CYC = `MFMC_BACK_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire mmc_clk,
	input wire mmc_cmd_i,
	input wire mmc_rst_n,
	output reg [7:0] mmc_dat_o,
	output reg [7:0] mmc_dat_oe,
	output reg boot_rd_req,
	output reg [2:0] boot_rd_src,
	output reg [31:0] boot_rd_addr,
	input wire [7:0] boot_rd_data,
	output reg acc_valid,
	output reg acc_write,
	output reg [2:0] acc_part,
	output reg [31:0] acc_addr,
	output reg [7:0] hs_timing,
	output reg [7:0] bus_width,
	output reg pwr_save
);
	localparam [6:0] S_PRE = 7'h01;
	localparam [6:0] S_BOOT = 7'h02;
	localparam [6:0] S_ACT = 7'h04;
	localparam [6:0] S_SLPT = 7'h08;
	localparam [6:0] S_SLP = 7'h10;
	localparam [6:0] S_WAKT = 7'h20;
	localparam [6:0] S_HRST = 7'h40;

	wire clk_rise;
	wire clk_fall;
	wire cmd_lvl;
	wire rst_rise;
	wire cmd_v;
	wire [5:0] idx;
	wire [31:0] arg;
	wire [31:0] enh_q;
	wire enh_lock;
	wire [31:0] gp_q;
	wire [3:0] gp_lock;
	wire [4:0] attr_q;
	wire attr_lock;

	reg [6:0] state_reg;
	reg [7:0] tmr_reg;
	reg [31:0] idle_reg;
	reg [31:0] ack_tmr_reg;
	reg [7:0] low_reg;
	reg [7:0] pcfg_reg;
	reg [7:0] bmult_reg;
	reg boot_err_reg;
	reg alt_reg;
	reg ack_done_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] sh_reg;
	reg [7:0] nxt_reg;
	reg [7:0] aw_addr_reg;
	reg aw_full_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_full_reg;
	reg [31:0] rd_mux;
	reg rd_err;

	mfmc_link_rx u_rx (
		.aclk(aclk),
		.aresetn(aresetn),
		.mmc_clk(mmc_clk),
		.mmc_cmd_i(mmc_cmd_i),
		.mmc_rst_n(mmc_rst_n),
		.clk_rise(clk_rise),
		.clk_fall(clk_fall),
		.cmd_lvl(cmd_lvl),
		.rst_rise(rst_rise),
		.frm_valid(cmd_v),
		.frm_idx(idx),
		.frm_arg(arg)
	);

	// register bus handshakes
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
	wire wr_bad = (aw_addr_reg[1:0] != 2'h0) || (aw_addr_reg > `MFMC_A_RPMB);

	// one-time partition settings
	mfmc_otp_field #(.W(32)) u_enh (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(wr_go && aw_addr_reg == `MFMC_A_ENH_USER && wstrb_reg == 4'hF),
		.d(wdata_reg),
		.q(enh_q),
		.lock(enh_lock)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_gp
			mfmc_otp_field #(.W(8)) u_gp (
				.aclk(aclk),
				.aresetn(aresetn),
				.wr(wr_go && aw_addr_reg == `MFMC_A_GP_SIZE && wstrb_reg[gi]),
				.d(wdata_reg[8*gi+7:8*gi]),
				.q(gp_q[8*gi+7:8*gi]),
				.lock(gp_lock[gi])
			);
		end
	endgenerate
	mfmc_otp_field #(.W(5)) u_attr (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(wr_go && aw_addr_reg == `MFMC_A_PART_ATTR && wstrb_reg[0]),
		.d(wdata_reg[4:0]),
		.q(attr_q),
		.lock(attr_lock)
	);

	// command decode
	wire c_rst0 = cmd_v && idx == `MFMC_CMD_RESET &&
		(arg == `MFMC_ARG_GO_IDLE || arg == `MFMC_ARG_PRE_IDLE);
	wire c_boot0 = cmd_v && idx == `MFMC_CMD_RESET && arg == `MFMC_ARG_BOOT;
	wire c_slp = cmd_v && idx == `MFMC_CMD_SLEEP;
	wire c_sw = cmd_v && idx == `MFMC_CMD_SWITCH && arg[25:24] == `MFMC_SW_WRB;
	wire c_rd = idx == `MFMC_CMD_RD1 || idx == `MFMC_CMD_RDM;
	wire c_wr = idx == `MFMC_CMD_WR1 || idx == `MFMC_CMD_WRM;
	wire [2:0] bsrc = pcfg_reg[5:3];
	wire boot_en = bsrc == 3'h1 || bsrc == 3'h2 || bsrc == 3'h7;
	wire bw_ok = arg[15:8] <= 8'h02 || arg[15:8] == 8'h05 || arg[15:8] == 8'h06;
	wire busy_st = (state_reg & (S_HRST | S_SLPT | S_WAKT)) != 7'h00;

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= S_PRE;
			tmr_reg <= 8'h00;
			idle_reg <= 32'h0;
			ack_tmr_reg <= 32'h0;
			low_reg <= 8'h00;
			pcfg_reg <= 8'h00;
			bmult_reg <= `MFMC_BOOT_MULT_RST;
			boot_err_reg <= 1'b0;
			alt_reg <= 1'b0;
			ack_done_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			nxt_reg <= 8'h00;
			mmc_dat_o <= 8'hFF;
			mmc_dat_oe <= 8'h00;
			boot_rd_req <= 1'b0;
			boot_rd_src <= 3'h0;
			boot_rd_addr <= 32'h0;
			acc_valid <= 1'b0;
			acc_write <= 1'b0;
			acc_part <= 3'h0;
			acc_addr <= 32'h0;
			hs_timing <= 8'h00;
			bus_width <= 8'h00;
			pwr_save <= 1'b0;
		end else begin
			boot_rd_req <= 1'b0;
			acc_valid <= 1'b0;
			if (boot_rd_req)
				nxt_reg <= boot_rd_data;
			// software side of the boot configuration and boot size
			if (wr_go && aw_addr_reg == `MFMC_A_BOOT_CFG && wstrb_reg[0])
				pcfg_reg <= wdata_reg[7:0];
			if (wr_go && aw_addr_reg == `MFMC_A_BOOT_SIZE && wstrb_reg[0])
				bmult_reg <= wdata_reg[7:0];
			// long command-low count before the first command
			if (state_reg != S_PRE || cmd_lvl)
				low_reg <= 8'h00;
			else if (clk_rise && low_reg != `MFMC_BOOT_LOW)
				low_reg <= low_reg + 8'h01;
			if (rst_rise) begin
				state_reg <= S_HRST;
				tmr_reg <= 8'h00;
				hs_timing <= 8'h00;
				bus_width <= 8'h00;
				pcfg_reg[2:0] <= 3'h0;
				pwr_save <= 1'b0;
				mmc_dat_oe <= 8'h00;
			end else if (c_rst0 && !busy_st) begin
				state_reg <= S_PRE;
				hs_timing <= 8'h00;
				bus_width <= 8'h00;
				pwr_save <= 1'b0;
				mmc_dat_oe <= 8'h00;
			end else begin
				case (state_reg)
				S_HRST: begin
					if (tmr_reg == `MFMC_RST_SEQ)
						state_reg <= S_PRE;
					else
						tmr_reg <= tmr_reg + 8'h01;
				end
				S_PRE: begin
					if (boot_en && (c_boot0 || low_reg == `MFMC_BOOT_LOW)) begin
						state_reg <= S_BOOT;
						alt_reg <= c_boot0;
						boot_err_reg <= 1'b0;
						ack_tmr_reg <= 32'h0;
						ack_done_reg <= 1'b0;
						sh_reg <= 8'h40;
						bit_cnt_reg <= 4'h3;
						mmc_dat_o[0] <= 1'b1;
						mmc_dat_oe[0] <= 1'b1;
						boot_rd_src <= bsrc;
						boot_rd_addr <= 32'h0;
						boot_rd_req <= 1'b1;
					end else if (cmd_v && idx == `MFMC_CMD_OPCOND) begin
						state_reg <= S_ACT;
						idle_reg <= 32'h0;
					end
				end
				S_BOOT: begin
					if (!ack_done_reg)
						ack_tmr_reg <= ack_tmr_reg + 32'h1;
					if (!ack_done_reg && ack_tmr_reg == BACK_CYC) begin
						state_reg <= S_PRE;
						boot_err_reg <= 1'b1;
						mmc_dat_oe[0] <= 1'b0;
					end else if (!alt_reg && cmd_lvl) begin
						state_reg <= S_PRE;
						mmc_dat_oe[0] <= 1'b0;
					end else if (clk_fall) begin
						mmc_dat_o[0] <= sh_reg[7];
						if (bit_cnt_reg == 4'h1) begin
							// ack sent, data follows without a gap
							sh_reg <= nxt_reg;
							bit_cnt_reg <= 4'h8;
							ack_done_reg <= 1'b1;
							boot_rd_addr <= boot_rd_addr + 32'h1;
							boot_rd_req <= 1'b1;
						end else begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg - 4'h1;
						end
					end
				end
				S_ACT: begin
					if (cmd_v) begin
						idle_reg <= 32'h0;
						pwr_save <= 1'b0;
					end else if (idle_reg == IDLE_CYC) begin
						pwr_save <= 1'b1;
					end else begin
						idle_reg <= idle_reg + 32'h1;
					end
					if (c_slp && arg[`MFMC_SLP_BIT]) begin
						state_reg <= S_SLPT;
						tmr_reg <= 8'h00;
						pwr_save <= 1'b0;
					end else if (c_sw && arg[23:16] == `MFMC_X_HS) begin
						hs_timing <= arg[15:8];
					end else if (c_sw && arg[23:16] == `MFMC_X_BW && bw_ok) begin
						bus_width <= arg[15:8];
					end else if (c_sw && arg[23:16] == `MFMC_X_PCFG) begin
						pcfg_reg <= arg[15:8];
					end else if (cmd_v && (c_rd || c_wr)) begin
						acc_valid <= 1'b1;
						acc_write <= c_wr;
						acc_part <= pcfg_reg[2:0];
						acc_addr <= arg;
					end
				end
				S_SLPT: begin
					if (tmr_reg == `MFMC_SA_CYC)
						state_reg <= S_SLP;
					else
						tmr_reg <= tmr_reg + 8'h01;
				end
				S_SLP: begin
					// all but reset and wake are dropped here
					if (c_slp && !arg[`MFMC_SLP_BIT]) begin
						state_reg <= S_WAKT;
						tmr_reg <= 8'h00;
					end
				end
				S_WAKT: begin
					if (tmr_reg == `MFMC_SA_CYC) begin
						state_reg <= S_ACT;
						idle_reg <= 32'h0;
					end else begin
						tmr_reg <= tmr_reg + 8'h01;
					end
				end
				default: state_reg <= S_PRE;
				endcase
			end
		end
	end

	// register bus slave, one write and one read at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0;
			aw_addr_reg <= 8'h00;
			aw_full_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			w_full_reg <= 1'b0;
		end else begin
			s_axi_awready <= wr_go | (~aw_full_reg & ~aw_hs);
			s_axi_wready <= wr_go | (~w_full_reg & ~w_hs);
			if (aw_hs) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end else if (wr_go) begin
				aw_full_reg <= 1'b0;
			end
			if (w_hs) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
			end else if (wr_go) begin
				w_full_reg <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_bad ? 2'h2 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~ar_hs & (~s_axi_rvalid | s_axi_rready);
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always @* begin
		rd_err = s_axi_araddr[1:0] != 2'h0;
		case (s_axi_araddr)
		`MFMC_A_BOOT_CFG: rd_mux = {24'h0, pcfg_reg};
		`MFMC_A_BOOT_SIZE: rd_mux = {1'b0, bmult_reg, 7'h00, 8'h00, bmult_reg};
		`MFMC_A_ENH_USER: rd_mux = enh_q;
		`MFMC_A_GP_SIZE: rd_mux = gp_q;
		`MFMC_A_PART_ATTR: rd_mux = {18'h0, attr_lock, enh_lock, gp_lock, 3'h0, attr_q};
		`MFMC_A_STATUS: rd_mux = {23'h0, boot_err_reg, pwr_save, state_reg};
		`MFMC_A_MODES: rd_mux = {8'h00, pcfg_reg, bus_width, hs_timing};
		`MFMC_A_DEV_TYPE: rd_mux = {24'h0, `MFMC_DEV_TYPE};
		`MFMC_A_SA_TMO: rd_mux = {24'h0, `MFMC_SA_TMO};
		`MFMC_A_RPMB: rd_mux = {16'h0, `MFMC_RPMB_KB};
		default: begin
			rd_mux = 32'h0;
			rd_err = 1'b1;
		end
		endcase
	end
endmodule
`default_nettype wire

// ### verilog/mfmc_regs.vh
// register map, command codes and timing for the flash mode control block
`ifndef MFMC_REGS_VH
`define MFMC_REGS_VH
`define MFMC_CLK_HZ 20000000
`define MFMC_CYC_PER_MS (`MFMC_CLK_HZ/1000)
`define MFMC_IDLE_MS 1000
`define MFMC_IDLE_CYC (`MFMC_IDLE_MS*`MFMC_CYC_PER_MS)
`define MFMC_BACK_MS 50
`define MFMC_BACK_CYC (`MFMC_BACK_MS*`MFMC_CYC_PER_MS)
`define MFMC_SA_TMO 8'h0A
`define MFMC_SA_CYC 8'h10
`define MFMC_RST_SEQ 8'h20
`define MFMC_BOOT_LOW 8'h4A
`define MFMC_A_BOOT_CFG 8'h00
`define MFMC_A_BOOT_SIZE 8'h04
`define MFMC_A_ENH_USER 8'h08
`define MFMC_A_GP_SIZE 8'h0C
`define MFMC_A_PART_ATTR 8'h10
`define MFMC_A_STATUS 8'h14
`define MFMC_A_MODES 8'h18
`define MFMC_A_DEV_TYPE 8'h1C
`define MFMC_A_SA_TMO 8'h20
`define MFMC_A_RPMB 8'h24
`define MFMC_BOOT_MULT_RST 8'h20
`define MFMC_DEV_TYPE 8'h57
`define MFMC_RPMB_KB 16'h1000
`define MFMC_CMD_RESET 6'h00
`define MFMC_CMD_OPCOND 6'h01
`define MFMC_CMD_SLEEP 6'h05
`define MFMC_CMD_SWITCH 6'h06
`define MFMC_CMD_RD1 6'h11
`define MFMC_CMD_RDM 6'h12
`define MFMC_CMD_WR1 6'h18
`define MFMC_CMD_WRM 6'h19
`define MFMC_ARG_GO_IDLE 32'h00000000
`define MFMC_ARG_PRE_IDLE 32'hF0F0F0F0
`define MFMC_ARG_BOOT 32'hFFFFFFFA
`define MFMC_SLP_BIT 15
`define MFMC_SW_WRB 2'h3
`define MFMC_X_HS 8'hB9
`define MFMC_X_BW 8'hB7
`define MFMC_X_PCFG 8'hB3
`define MFMC_HS_ON 8'h01
`endif

// ### verilog/mfmc_otp_field.v
// write-once configuration field with lock flag
`timescale 1ns/10ps
`default_nettype none
module mfmc_otp_field #(
	parameter W = 8
) (
	input wire aclk,
	input wire aresetn,
	input wire wr,
	input wire [W-1:0] d,
	output reg [W-1:0] q,
	output reg lock
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			q <= {W{1'b0}};
			lock <= 1'b0;
		end else if (wr && !lock) begin
			q <= d;
			lock <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verilog/mfmc_link_rx.v
// link pin sampling, edge detection and command frame capture
`timescale 1ns/10ps
`default_nettype none
module mfmc_link_rx (
	input wire aclk,
	input wire aresetn,
	input wire mmc_clk,
	input wire mmc_cmd_i,
	input wire mmc_rst_n,
	output reg clk_rise,
	output reg clk_fall,
	output wire cmd_lvl,
	output reg rst_rise,
	output reg frm_valid,
	output reg [5:0] frm_idx,
	output reg [31:0] frm_arg
);
	reg [2:0] s1_reg;
	reg [2:0] s2_reg;
	reg [2:0] s3_reg;
	reg [45:0] sh_reg;
	reg [5:0] cnt_reg;
	wire rise = s2_reg[0] & ~s3_reg[0];
	wire [46:0] frm = {sh_reg, s2_reg[1]};
	assign cmd_lvl = s3_reg[1];
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 3'h7;
			s2_reg <= 3'h7;
			s3_reg <= 3'h7;
			sh_reg <= 46'h0;
			cnt_reg <= 6'h00;
			clk_rise <= 1'b0;
			clk_fall <= 1'b0;
			rst_rise <= 1'b0;
			frm_valid <= 1'b0;
			frm_idx <= 6'h00;
			frm_arg <= 32'h0;
		end else begin
			s1_reg <= {mmc_rst_n, mmc_cmd_i, mmc_clk};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			clk_rise <= rise;
			clk_fall <= ~s2_reg[0] & s3_reg[0];
			rst_rise <= s2_reg[2] & ~s3_reg[2];
			frm_valid <= 1'b0;
			if (rise) begin
				if (cnt_reg == 6'h00) begin
					if (!s2_reg[1])
						cnt_reg <= 6'h01;
				end else begin
					sh_reg <= frm[45:0];
					if (cnt_reg == 6'h2F) begin
						cnt_reg <= 6'h00;
						// transmission bit and end bit must be high
						frm_valid <= frm[46] & frm[0];
						frm_idx <= frm[45:40];
						frm_arg <= frm[39:8];
					end else begin
						cnt_reg <= cnt_reg + 6'h01;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/mfmc_properties.sv
// port assertions for the mode control block
`timescale 1ns/10ps
`default_nettype none
module mfmc_props #(
	parameter [31:0] IDLE_CYC = 32'hC8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic mmc_rst_n,
	input wire logic [7:0] mmc_dat_oe,
	input wire logic boot_rd_req,
	input wire logic acc_valid,
	input wire logic [7:0] hs_timing,
	input wire logic [7:0] bus_width,
	input wire logic pwr_save
);
	logic [31:0] idle_cnt;
	// cycles since the last served access
	always @(posedge aclk) begin
		if (!aresetn || acc_valid) begin
			idle_cnt <= 32'h0;
		end else if (idle_cnt != 32'hFFFFFFFF) begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_pin_up;
		$rose(mmc_rst_n);
	endsequence
	sequence s_modes_clear;
		hs_timing == 8'h00 && bus_width == 8'h00;
	endsequence
	a_hw_reset_clears: assert property (s_pin_up |-> ##[1:8] s_modes_clear [*8])
		else $error("modes kept after reset pin rise");
	a_reset_modes: assert property ($rose(aresetn) |-> !pwr_save && hs_timing == 8'h00 && bus_width == 8'h00)
		else $error("modes not cleared by reset");
	a_oe_dat0_only: assert property (mmc_dat_oe[7:1] == 7'h00)
		else $error("unexpected data line driven");
	a_boot_fetch: assert property ($rose(mmc_dat_oe[0]) |-> boot_rd_req)
		else $error("boot start without first fetch");
	a_bw_legal: assert property (bus_width inside {8'h00, 8'h01, 8'h02, 8'h05, 8'h06})
		else $error("illegal bus width value");
	a_psave_idle: assert property ($rose(pwr_save) |-> idle_cnt >= IDLE_CYC - 32'h2)
		else $error("power save entered too early");
	a_psave_exit: assert property (acc_valid |-> ##[0:4] !pwr_save)
		else $error("power save kept after access");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_aw_blocked: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address taken before response");
endmodule
bind mfmc_top mfmc_props #(.IDLE_CYC(IDLE_CYC)) u_props (.*);
`default_nettype wire

// ### dv/mfmc_host.sv
// host model: link clock, command frames and reset pin
`timescale 1ns/10ps
`default_nettype none
module mfmc_host (
	input wire logic aclk,
	output logic mmc_clk,
	output logic mmc_cmd_i,
	output logic mmc_rst_n
);
	initial begin
		mmc_clk = 1'b1;
		mmc_cmd_i = 1'b1;
		mmc_rst_n = 1'b1;
	end
	// clock rests high outside frames, 2.5 MHz in frames, 450 ns periods in tick
	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
		logic [47:0] f;
		f = {2'b01, idx, arg, 8'h01};
		for (int i = 47; i >= 0; i--) begin
			@(posedge aclk);
			mmc_clk <= 1'b0;
			mmc_cmd_i <= f[i];
			repeat (4) @(posedge aclk);
			mmc_clk <= 1'b1;
			repeat (3) @(posedge aclk);
		end
		@(posedge aclk);
		mmc_cmd_i <= 1'b1;
		repeat (12) @(posedge aclk);
	endtask
	task automatic tick;
		@(posedge aclk);
		mmc_clk <= 1'b0;
		repeat (4) @(posedge aclk);
		mmc_clk <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask
	// command held low for whole frames so the receiver ends idle
	task automatic hold(input int n);
		@(posedge aclk);
		mmc_cmd_i <= 1'b0;
		repeat (n) tick();
	endtask
	task automatic free;
		@(posedge aclk);
		mmc_cmd_i <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask
	task automatic hrst;
		@(posedge aclk);
		mmc_rst_n <= 1'b0;
		repeat (10) @(posedge aclk);
		mmc_rst_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ### dv/mfmc_top_test.sv
// self-checking bench for the flash mode control block
`timescale 1ns/10ps
`default_nettype none
`include "mfmc_regs.vh"
module mfmc_top_test;
	localparam int IDLE = 200;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mmc_clk, mmc_cmd_i, mmc_rst_n;
	logic boot_rd_req, acc_valid, acc_write, pwr_save;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mmc_dat_o, mmc_dat_oe, hs_timing, bus_width;
	logic [31:0] s_axi_wdata, s_axi_rdata, boot_rd_addr, acc_addr, rv, la;
	logic [3:0] s_axi_wstrb, lp;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
	logic [2:0] boot_rd_src, acc_part;
	logic [18:0] bits;
	wire [7:0] boot_rd_data;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int na = 0;
	int n0;
	logic [2:0] srcs [3] = '{3'h1, 3'h2, 3'h7};
	logic [15:0] bws [6] = '{16'h0101, 16'h0202, 16'h0505, 16'h0606, 16'h0306, 16'h0000};
	logic [31:0] sres [2] = '{32'h0, 32'hF0F0F0F0};
	// boot store: byte marks source and address
	assign boot_rd_data = {boot_rd_src, 5'h15} ^ boot_rd_addr[7:0];
	mfmc_top #(.IDLE_CYC(IDLE), .BACK_CYC(32'h64)) uut (.*);
	mfmc_host h (.*);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (acc_valid === 1'b1) begin
			na++;
			la = acc_addr;
			lp = {acc_write, acc_part};
		end
		if (cyc == 60000) begin
			n_fail++;
			results();
		end
	end
	task automatic chk(input logic [31:0] v, e, input string n);
		check_count++;
		if (v !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", n, e, v);
		end
	endtask
	task automatic results;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		// late response ready lets the slave hold its answer
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		rd(a);
		chk(rv & m, e, "reg");
	endtask
	// second write to a write-once field must be ignored
	task automatic otp(input logic [7:0] a, input logic [31:0] v, m);
		wr(a, v, 4'hF);
		wr(a, ~v, 4'hF);
		rc(a, m, v & m);
	endtask
	task automatic sw(input logic [7:0] x, v);
		h.cmd(`MFMC_CMD_SWITCH, {6'h00, `MFMC_SW_WRB, x, v, 8'h00});
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`MFMC_A_DEV_TYPE, 32'hFF, 32'h57);
		rc(`MFMC_A_SA_TMO, 32'hFF, 32'h0A);
		rc(`MFMC_A_RPMB, 32'hFFFF, 32'h1000);
		rc(`MFMC_A_BOOT_SIZE, 32'hFFFF00FF, 32'h10000020);
		rc(`MFMC_A_MODES, 32'hFFFF, 32'h0);
		rd(8'h28);
		chk(rr, 2'h2, "unmapped");
		wr(8'h28, 32'h0, 4'hF);
		chk(br, 2'h2, "wr_unmapped");
		wr(`MFMC_A_BOOT_SIZE, 32'h55550003, 4'hF);
		chk(br, 2'h0, "wr_okay");
		rc(`MFMC_A_BOOT_SIZE, 32'hFFFF00FF, 32'h01800003);
		otp(`MFMC_A_ENH_USER, 32'h00050003, 32'hFFFFFFFF);
		otp(`MFMC_A_GP_SIZE, 32'h04030201, 32'hFFFFFFFF);
		otp(`MFMC_A_PART_ATTR, 32'h11, 32'h1F);
		$display("end registers");
		foreach (srcs[i]) begin
			wr(`MFMC_A_BOOT_CFG, {26'h0, srcs[i], 3'h0}, 4'h1);
			h.cmd(`MFMC_CMD_RESET, `MFMC_ARG_BOOT);
			chk(mmc_dat_oe, 8'h01, "boot_oe");
			for (int k = 0; k < 19; k++) begin
				h.tick();
				bits = {bits[17:0], mmc_dat_o[0]};
			end
			chk(bits, {3'b010, srcs[i], 5'h15, srcs[i], 5'h14}, "boot_bits");
			h.cmd(`MFMC_CMD_RESET, `MFMC_ARG_GO_IDLE);
			chk(mmc_dat_oe, 8'h00, "boot_end");
		end
		h.hold(96);
		chk(mmc_dat_oe, 8'h01, "hold_oe");
		h.free();
		chk(mmc_dat_oe, 8'h00, "hold_end");
		h.cmd(`MFMC_CMD_RESET, `MFMC_ARG_BOOT);
		repeat (120) @(posedge aclk);
		rc(`MFMC_A_STATUS, 32'h1FF, 32'h101);
		chk(mmc_dat_oe, 8'h00, "abort_oe");
		$display("end boot");
		h.cmd(`MFMC_CMD_OPCOND, 32'h0);
		rc(`MFMC_A_STATUS, 32'h7F, 32'h04);
		h.cmd(`MFMC_CMD_RD1, 32'h100);
		chk(la, 32'h100, "rd_addr");
		chk(lp, 4'h0, "rd_part");
		sw(`MFMC_X_HS, `MFMC_HS_ON);
		chk(hs_timing, 8'h01, "hs");
		foreach (bws[i]) begin
			sw(`MFMC_X_BW, bws[i][15:8]);
			chk(bus_width, bws[i][7:0], "bw");
		end
		sw(`MFMC_X_PCFG, 8'h02);
		h.cmd(`MFMC_CMD_WR1, 32'h40);
		chk(la, 32'h40, "wr_addr");
		chk(lp, 4'hA, "wr_part");
		$display("end switch");
		repeat (IDLE + 20) @(posedge aclk);
		chk(pwr_save, 1'b1, "psave");
		h.cmd(`MFMC_CMD_RD1, 32'h8);
		chk(pwr_save, 1'b0, "psave_exit");
		chk(la, 32'h8, "psave_rd");
		h.cmd(`MFMC_CMD_SLEEP, 32'h8000);
		repeat (20) @(posedge aclk);
		rc(`MFMC_A_STATUS, 32'h7F, 32'h10);
		n0 = na;
		h.cmd(`MFMC_CMD_RD1, 32'h4);
		sw(`MFMC_X_BW, 8'h02);
		chk(na, n0, "slp_acc");
		chk(bus_width, 8'h00, "slp_bw");
		h.cmd(`MFMC_CMD_SLEEP, 32'h0);
		repeat (20) @(posedge aclk);
		rc(`MFMC_A_STATUS, 32'h7F, 32'h04);
		$display("end power");
		sw(`MFMC_X_BW, 8'h02);
		sw(`MFMC_X_HS, `MFMC_HS_ON);
		h.hrst();
		repeat (50) @(posedge aclk);
		chk({hs_timing, bus_width}, 16'h0, "hrst_modes");
		rc(`MFMC_A_STATUS, 32'h7F, 32'h01);
		foreach (sres[i]) begin
			h.cmd(`MFMC_CMD_OPCOND, 32'h0);
			sw(`MFMC_X_BW, 8'h01);
			h.cmd(`MFMC_CMD_RESET, sres[i]);
			chk(bus_width, 8'h00, "soft_bw");
		end
		$display("end resets");
		results();
	end
endmodule
`default_nettype wire
